// ===== logic/fcq_host.sv
// Host controller that drives a parallel flash through its pins.
// Software orders operations over a classic Wishbone slave port; the
// flash sees ordinary asynchronous write and read cycles.
//
// Design decisions made here: the register offsets and the Wishbone register port.
`include "fcq_defs.svh"

module fcq_host #(
  parameter int AW = 24,
  parameter int DEPTH = 32,
  parameter int WE_CYC = `FCQ_WE_CYC,
  parameter int RD_CYC = `FCQ_RD_CYC,
  parameter int RP_CYC = `FCQ_RP_CYC,
  parameter int REC_CYC = `FCQ_REC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [AW-1:0] flash_addr_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_rp_n_o,
  output logic flash_byte_n_o,
  output logic flash_vpen_o,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_n_o
);

  localparam int BW = $clog2(DEPTH);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function automatic fcq_pkg::fcq_step_type mk(
      input fcq_pkg::fcq_kind_type kind, input logic [7:0] code);
    mk = '{kind: kind, code: code};
  endfunction : mk

  // One bus cycle per step; unknown ops end at once.
  function automatic fcq_pkg::fcq_step_type plan(
      input fcq_pkg::fcq_op_type op, input logic [2:0] step);
    fcq_pkg::fcq_step_type s;
    s = mk(fcq_pkg::FCQ_K_END, 8'h00);
    case (op)
      fcq_pkg::FCQ_OP_ARRAY:
        if (step == 3'h0) s = mk(fcq_pkg::FCQ_K_WCODE, `FCQ_CMD_ARRAY);
      fcq_pkg::FCQ_OP_CLRST:
        if (step == 3'h0) s = mk(fcq_pkg::FCQ_K_WCODE, `FCQ_CMD_CLRST);
      fcq_pkg::FCQ_OP_SUSPEND:
        if (step == 3'h0) s = mk(fcq_pkg::FCQ_K_WCODE, `FCQ_CMD_SUSPEND);
      fcq_pkg::FCQ_OP_RESUME:
        if (step == 3'h0) s = mk(fcq_pkg::FCQ_K_WCODE, `FCQ_CMD_CONFIRM);
      fcq_pkg::FCQ_OP_IDENT, fcq_pkg::FCQ_OP_STATUS: begin
        if (step == 3'h0) s = mk(fcq_pkg::FCQ_K_WCODE,
            op == fcq_pkg::FCQ_OP_IDENT ? `FCQ_CMD_IDENT : `FCQ_CMD_STATUS);
        else if (step == 3'h1) s = mk(fcq_pkg::FCQ_K_RLO, 8'h00);
      end
      fcq_pkg::FCQ_OP_QUERY: begin
        if (step == 3'h0) s = mk(fcq_pkg::FCQ_K_WCODE, `FCQ_CMD_QUERY);
        else if (step == 3'h1) s = mk(fcq_pkg::FCQ_K_RLO, 8'h00);
        else if (step == 3'h2) s = mk(fcq_pkg::FCQ_K_RHI, 8'h00);
      end
      fcq_pkg::FCQ_OP_PROG, fcq_pkg::FCQ_OP_CONFIG, fcq_pkg::FCQ_OP_PROT: begin
        if (step == 3'h0) s = mk(fcq_pkg::FCQ_K_WCODE,
            op == fcq_pkg::FCQ_OP_PROG ? `FCQ_CMD_PROG :
            op == fcq_pkg::FCQ_OP_CONFIG ? `FCQ_CMD_CONFIG : `FCQ_CMD_PROT);
        else if (step == 3'h1) s = mk(fcq_pkg::FCQ_K_WPAY, 8'h00);
        else if (step == 3'h2 && op != fcq_pkg::FCQ_OP_CONFIG)
          s = mk(fcq_pkg::FCQ_K_RPOLL, 8'h00);
      end
      fcq_pkg::FCQ_OP_ERASE, fcq_pkg::FCQ_OP_LOCKSET,
      fcq_pkg::FCQ_OP_LOCKCLR: begin
        if (step == 3'h0) s = mk(fcq_pkg::FCQ_K_WCODE,
            op == fcq_pkg::FCQ_OP_ERASE ? `FCQ_CMD_ERASE : `FCQ_CMD_LOCK);
        else if (step == 3'h1) s = mk(fcq_pkg::FCQ_K_WCODE,
            op == fcq_pkg::FCQ_OP_LOCKSET ? `FCQ_CMD_LOCKSET :
            `FCQ_CMD_CONFIRM);
        else if (step == 3'h2) s = mk(fcq_pkg::FCQ_K_RPOLL, 8'h00);
      end
      fcq_pkg::FCQ_OP_BUFPROG: begin
        if (step == 3'h0) s = mk(fcq_pkg::FCQ_K_WCODE, `FCQ_CMD_BUFPROG);
        else if (step == 3'h1) s = mk(fcq_pkg::FCQ_K_RAVAIL, 8'h00);
        else if (step == 3'h2) s = mk(fcq_pkg::FCQ_K_WCNT, 8'h00);
        else if (step == 3'h3) s = mk(fcq_pkg::FCQ_K_WBUF, 8'h00);
        else if (step == 3'h4) s = mk(fcq_pkg::FCQ_K_WCODE, `FCQ_CMD_CONFIRM);
        else if (step == 3'h5) s = mk(fcq_pkg::FCQ_K_RPOLL, 8'h00);
      end
      default: s = mk(fcq_pkg::FCQ_K_END, 8'h00);
    endcase
    plan = s;
  endfunction : plan

  function automatic logic alters(input fcq_pkg::fcq_op_type op);
    alters = op inside {fcq_pkg::FCQ_OP_PROG, fcq_pkg::FCQ_OP_ERASE,
                        fcq_pkg::FCQ_OP_LOCKSET, fcq_pkg::FCQ_OP_LOCKCLR,
                        fcq_pkg::FCQ_OP_BUFPROG, fcq_pkg::FCQ_OP_PROT};
  endfunction : alters

  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [15:0] val, input logic [1:0] sel);
    merge16 = {sel[1] ? val[15:8] : old[15:8], sel[0] ? val[7:0] : old[7:0]};
  endfunction : merge16

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  fcq_pkg::fcq_state_type st, next_st;
  fcq_pkg::fcq_op_type op, next_op;
  fcq_pkg::fcq_step_type cur, next_cur;
  fcq_pkg::fcq_mode_type mode, next_mode;
  logic [2:0] step, next_step;
  logic [BW-1:0] bi, next_bi;
  logic [BW:0] fill, next_fill;
  logic [7:0] tcnt, next_tcnt;
  logic [2:0] cfg, next_cfg;
  logic [AW-1:0] addr, next_addr;
  logic [15:0] wdata, next_wdata, rdata, next_rdata;
  logic busy, next_busy, err, next_err, ack, next_ack;
  logic [31:0] next_wb_dat;
  logic [AW-1:0] next_fa;
  logic next_ce_n, next_oe_n, next_we_n, next_rp_n, next_vpen, next_dq_oe_n;
  logic [15:0] next_dq;
  logic [15:0] buf_mem [DEPTH];
  logic access, wr, buf_push, cnt_ok;
  logic [15:0] cnt_max;

  assign access = wb_cyc_i & wb_stb_i & ~ack;
  assign wr = access & wb_we_i;
  assign buf_push = wr && wb_adr_i == `FCQ_REG_BUF && wb_sel_i[0] &&
                    st == fcq_pkg::FCQ_ST_IDLE && fill < (BW+1)'(DEPTH);
  assign cnt_max = cfg[`FCQ_CFG_BYTE] ? `FCQ_CNT_MAX_BYTE : `FCQ_CNT_MAX_WORD;
  assign cnt_ok = fill != '0 && 16'(fill) - 16'h0001 <= cnt_max;
  assign wb_ack_o = ack;
  assign flash_byte_n_o = ~cfg[`FCQ_CFG_BYTE];

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    logic adv;
    logic [AW-1:0] off;
    logic [31:0] sts;
    adv = 1'b0;
    off = addr;
    sts = '0;
    next_st = st; next_op = op; next_cur = cur; next_mode = mode;
    next_step = step; next_bi = bi; next_fill = fill; next_tcnt = tcnt;
    next_cfg = cfg; next_addr = addr; next_wdata = wdata;
    next_rdata = rdata; next_busy = busy; next_err = err;
    next_ack = access;
    next_fa = flash_addr_o; next_ce_n = flash_ce_n_o;
    next_oe_n = flash_oe_n_o; next_we_n = flash_we_n_o;
    next_rp_n = flash_rp_n_o; next_dq = flash_dq_o;
    next_dq_oe_n = flash_dq_oe_n_o;
    next_vpen = cfg[`FCQ_CFG_VPEN] | (busy & alters(op));
    // ------------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------------
    // Recovery counts as busy: a command written then would be dropped
    sts[`FCQ_STS_BUSY] = busy | (st == fcq_pkg::FCQ_ST_RESET);
    sts[`FCQ_STS_ERR] = err;
    sts[`FCQ_STS_RP] = flash_rp_n_o;
    sts[`FCQ_STS_MODE +: 2] = mode;
    sts[`FCQ_STS_FILL +: BW+1] = fill;
    next_wb_dat = wb_dat_o;
    if (access && !wb_we_i) begin
      if (wb_adr_i == `FCQ_REG_ADDR) next_wb_dat = 32'(addr);
      else if (wb_adr_i == `FCQ_REG_WDATA) next_wb_dat = {16'h0000, wdata};
      else if (wb_adr_i == `FCQ_REG_STATUS) next_wb_dat = sts;
      else if (wb_adr_i == `FCQ_REG_RDATA) next_wb_dat = {16'h0000, rdata};
      else if (wb_adr_i == `FCQ_REG_CFG) next_wb_dat = {29'h0, cfg};
      else next_wb_dat = 32'h0000_0000;
    end
    if (wr && !busy) begin
      if (wb_adr_i == `FCQ_REG_ADDR)
        next_addr = AW'({merge16(16'(addr[AW-1:16]), wb_dat_i[31:16],
                                 wb_sel_i[3:2]),
                         merge16(addr[15:0], wb_dat_i[15:0], wb_sel_i[1:0])});
      else if (wb_adr_i == `FCQ_REG_WDATA)
        next_wdata = merge16(wdata, wb_dat_i[15:0], wb_sel_i[1:0]);
      else if (wb_adr_i == `FCQ_REG_CFG && wb_sel_i[0]) next_cfg = wb_dat_i[2:0];
      else if (wb_adr_i == `FCQ_REG_STATUS && wb_sel_i[0]) next_err = 1'b0;
    end
    if (buf_push) next_fill = fill + (BW+1)'(1);
    // ------------------------------------------------------------------
    // Flash sequencer
    // ------------------------------------------------------------------
    case (st)
      fcq_pkg::FCQ_ST_RESET: begin
        if (tcnt != 8'h00) next_tcnt = tcnt - 8'h01;
        else if (!flash_rp_n_o) begin
          // Power-down holds the pin low until software clears it
          if (!cfg[`FCQ_CFG_PDOWN]) begin
            next_rp_n = 1'b1;
            next_tcnt = 8'(REC_CYC);
          end
        end else begin
          next_mode = fcq_pkg::FCQ_MODE_ARRAY;
          next_st = fcq_pkg::FCQ_ST_IDLE;
        end
      end
      fcq_pkg::FCQ_ST_IDLE: begin
        if (cfg[`FCQ_CFG_PDOWN]) begin
          next_rp_n = 1'b0;
          next_tcnt = 8'(RP_CYC);
          next_st = fcq_pkg::FCQ_ST_RESET;
        end else if (wr && wb_adr_i == `FCQ_REG_CMD && wb_sel_i[0]) begin
          next_op = fcq_pkg::fcq_op_type'(wb_dat_i[3:0]);
          next_step = 3'h0;
          next_bi = '0;
          if (wb_dat_i[3:0] == fcq_pkg::FCQ_OP_BUFPROG && !cnt_ok)
            next_err = 1'b1;
          else begin
            next_busy = 1'b1;
            next_st = fcq_pkg::FCQ_ST_LOAD;
          end
        end
      end
      fcq_pkg::FCQ_ST_LOAD: begin
        next_cur = plan(op, step);
        if (next_cur.kind == fcq_pkg::FCQ_K_END) begin
          next_busy = 1'b0;
          if (op == fcq_pkg::FCQ_OP_BUFPROG) next_fill = '0;
          next_st = fcq_pkg::FCQ_ST_IDLE;
        end else begin
          if (op == fcq_pkg::FCQ_OP_QUERY) begin
            off = addr + AW'(next_cur.kind == fcq_pkg::FCQ_K_RHI);
            if (cfg[`FCQ_CFG_BYTE]) off = off << 1;
          end else if (next_cur.kind == fcq_pkg::FCQ_K_WBUF)
            off = addr + AW'(bi);
          next_fa = off;
          next_ce_n = 1'b0;
          if (next_cur.kind inside {fcq_pkg::FCQ_K_RLO, fcq_pkg::FCQ_K_RHI,
              fcq_pkg::FCQ_K_RAVAIL, fcq_pkg::FCQ_K_RPOLL}) begin
            next_oe_n = 1'b0;
            next_dq_oe_n = 1'b1;
            next_tcnt = 8'(RD_CYC - 1);
          end else begin
            next_we_n = 1'b0;
            next_dq_oe_n = 1'b0;
            next_tcnt = 8'(WE_CYC - 1);
            case (next_cur.kind)
              fcq_pkg::FCQ_K_WPAY: next_dq = wdata;
              fcq_pkg::FCQ_K_WCNT: next_dq = 16'(fill) - 16'h0001;
              fcq_pkg::FCQ_K_WBUF: next_dq = buf_mem[bi];
              default: next_dq = {8'h00, next_cur.code};
            endcase
          end
          next_st = fcq_pkg::FCQ_ST_STROBE;
        end
      end
      fcq_pkg::FCQ_ST_STROBE: begin
        if (tcnt != 8'h00) next_tcnt = tcnt - 8'h01;
        else if (!flash_oe_n_o) begin
          next_oe_n = 1'b1;
          next_ce_n = 1'b1;
          adv = 1'b1;
          next_st = fcq_pkg::FCQ_ST_GAP;
        end else begin
          // Data stays on the bus past the rising strobe
          next_we_n = 1'b1;
          next_st = fcq_pkg::FCQ_ST_HOLD;
        end
      end
      fcq_pkg::FCQ_ST_HOLD: begin
        next_ce_n = 1'b1;
        next_dq_oe_n = 1'b1;
        adv = 1'b1;
        next_st = fcq_pkg::FCQ_ST_GAP;
      end
      fcq_pkg::FCQ_ST_GAP: next_st = fcq_pkg::FCQ_ST_LOAD;
      default: next_st = fcq_pkg::FCQ_ST_IDLE;
    endcase
    if (adv) begin
      next_step = step + 3'h1;
      case (cur.kind)
        fcq_pkg::FCQ_K_WCODE: begin
          case (cur.code)
            `FCQ_CMD_ARRAY: next_mode = fcq_pkg::FCQ_MODE_ARRAY;
            `FCQ_CMD_IDENT: next_mode = fcq_pkg::FCQ_MODE_IDENT;
            `FCQ_CMD_QUERY: next_mode = fcq_pkg::FCQ_MODE_QUERY;
            `FCQ_CMD_CLRST, `FCQ_CMD_SUSPEND: next_mode = mode;
            default: next_mode = fcq_pkg::FCQ_MODE_STATUS;
          endcase
        end
        fcq_pkg::FCQ_K_WBUF:
          if ((BW+1)'(bi) != fill - (BW+1)'(1)) begin
            next_bi = bi + BW'(1);
            next_step = step;
          end
        fcq_pkg::FCQ_K_RLO:
          next_rdata = (op == fcq_pkg::FCQ_OP_QUERY || cfg[`FCQ_CFG_BYTE]) ?
                       {8'h00, flash_dq_i[7:0]} : flash_dq_i;
        fcq_pkg::FCQ_K_RHI: next_rdata[15:8] = flash_dq_i[7:0];
        fcq_pkg::FCQ_K_RAVAIL:
          if (!flash_dq_i[`FCQ_READY_BIT]) next_step = 3'h0;
        fcq_pkg::FCQ_K_RPOLL: begin
          next_rdata = {8'h00, flash_dq_i[7:0]};
          if (!flash_dq_i[`FCQ_READY_BIT]) next_step = step;
        end
        default: next_step = step + 3'h1;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= fcq_pkg::FCQ_ST_RESET; op <= fcq_pkg::FCQ_OP_ARRAY;
      cur <= '0; mode <= fcq_pkg::FCQ_MODE_ARRAY; step <= '0; bi <= '0;
      fill <= '0; tcnt <= 8'(RP_CYC); cfg <= '0; addr <= '0;
      wdata <= '0; rdata <= '0; busy <= 1'b0; err <= 1'b0; ack <= 1'b0;
      wb_dat_o <= '0; flash_addr_o <= '0; flash_ce_n_o <= 1'b1;
      flash_oe_n_o <= 1'b1; flash_we_n_o <= 1'b1;
      flash_rp_n_o <= 1'b0;
      flash_vpen_o <= 1'b0; flash_dq_o <= '0; flash_dq_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      st <= next_st; op <= next_op; cur <= next_cur; mode <= next_mode;
      step <= next_step; bi <= next_bi; fill <= next_fill;
      tcnt <= next_tcnt; cfg <= next_cfg; addr <= next_addr;
      wdata <= next_wdata; rdata <= next_rdata; busy <= next_busy;
      err <= next_err; ack <= next_ack; wb_dat_o <= next_wb_dat;
      flash_addr_o <= next_fa; flash_ce_n_o <= next_ce_n;
      flash_oe_n_o <= next_oe_n; flash_we_n_o <= next_we_n;
      flash_rp_n_o <= next_rp_n; flash_vpen_o <= next_vpen;
      flash_dq_o <= next_dq; flash_dq_oe_n_o <= next_dq_oe_n;
    end
  end

  // Write buffer; filled only while idle so the sequencer reads stable data
  always_ff @(posedge clk_i) begin
    if (ce_i && buf_push) buf_mem[fill[BW-1:0]] <= wb_dat_i[15:0];
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic [BW:0] wbuf_done;
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && st == fcq_pkg::FCQ_ST_IDLE)) wbuf_done <= '0;
    else if (ce_i && st == fcq_pkg::FCQ_ST_HOLD &&
             cur.kind == fcq_pkg::FCQ_K_WBUF)
      wbuf_done <= wbuf_done + (BW+1)'(1);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_rp_reset_low: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !flash_rp_n_o) else $error("power-down pin not low in reset");
  chk_array_code: assert property (
    (st == fcq_pkg::FCQ_ST_STROBE && op == fcq_pkg::FCQ_OP_ARRAY &&
     !flash_we_n_o) |-> flash_dq_o == 16'h00FF)
    else $error("array-read write does not carry FFh");
  chk_cmd_upper_zero: assert property (
    (!flash_we_n_o && cur.kind == fcq_pkg::FCQ_K_WCODE) |->
    flash_dq_o[15:8] == 8'h00) else $error("command upper byte not zero");
  chk_we_oe_excl: assert property (
    !(!flash_we_n_o && !flash_oe_n_o)) else $error("write and read overlap");
  chk_data_hold: assert property (
    $rose(flash_we_n_o) |-> !flash_dq_oe_n_o && $stable(flash_dq_o) &&
    !flash_ce_n_o) else $error("data released at write strobe edge");
  chk_vpen_alter: assert property (
    (!flash_we_n_o && busy && alters(op)) |-> flash_vpen_o)
    else $error("altering command without program enable");
  chk_confirm_count: assert property (
    (st == fcq_pkg::FCQ_ST_STROBE && op == fcq_pkg::FCQ_OP_BUFPROG &&
     step == 3'h4) |-> wbuf_done == fill)
    else $error("confirm not after n+1 data writes");
  chk_count_range: assert property (
    (!flash_we_n_o && cur.kind == fcq_pkg::FCQ_K_WCNT) |->
    flash_dq_o <= cnt_max)
    else $error("buffer count out of range");
  chk_query_addr: assert property (
    (ce_i && st == fcq_pkg::FCQ_ST_LOAD && op == fcq_pkg::FCQ_OP_QUERY &&
     step == 3'h1 && cfg[`FCQ_CFG_BYTE]) |=> flash_addr_o == AW'(addr << 1))
    else $error("byte-mode query address not doubled");
  chk_poll_wait: assert property (
    (ce_i && st == fcq_pkg::FCQ_ST_STROBE && tcnt == 8'h00 && !flash_oe_n_o &&
     cur.kind == fcq_pkg::FCQ_K_RPOLL && !flash_dq_i[`FCQ_READY_BIT])
    |=> ##[1:2] (st == fcq_pkg::FCQ_ST_LOAD && step == $past(step, 2)))
    else $error("status poll left while engine busy");

  cov_buf_prog: cover property (st == fcq_pkg::FCQ_ST_STROBE &&
    op == fcq_pkg::FCQ_OP_BUFPROG && step == 3'h4);
  cov_query_id: cover property (op == fcq_pkg::FCQ_OP_QUERY &&
    addr == AW'(`FCQ_QUERY_ID_OFF) && st == fcq_pkg::FCQ_ST_STROBE);
  cov_poll_repeat: cover property (cur.kind == fcq_pkg::FCQ_K_RPOLL &&
    st == fcq_pkg::FCQ_ST_GAP ##2 cur.kind == fcq_pkg::FCQ_K_RPOLL);

endmodule : fcq_host

// ===== logic/fcq_defs.svh
// Constants for the flash command host: bus codes, register map, timing.
// Assumes a 16-bit capable parallel flash on the far side of the pins.
//
// Behaviour
// - One write of FFh anywhere returns the device to array reads.
// - Buffered program: E8h, count n, n+1 data writes, then D0h.
// - Count n is 00h..1Fh in byte mode, 0000h..000Fh in word mode.
// - After E8h the host checks buffer availability before loading.
// - In 8-bit mode the host drives the lowest address lines.
`ifndef FCQ_DEFS_SVH
`define FCQ_DEFS_SVH

`define FCQ_CMD_ARRAY 8'hFF
`define FCQ_CMD_IDENT 8'h90
`define FCQ_CMD_QUERY 8'h98
`define FCQ_CMD_STATUS 8'h70
`define FCQ_CMD_CLRST 8'h50
`define FCQ_CMD_BUFPROG 8'hE8
`define FCQ_CMD_PROG 8'h40
`define FCQ_CMD_CONFIRM 8'hD0
`define FCQ_CMD_ERASE 8'h20
`define FCQ_CMD_SUSPEND 8'hB0
`define FCQ_CMD_LOCK 8'h60
`define FCQ_CMD_LOCKSET 8'h01
`define FCQ_CMD_CONFIG 8'hB8
`define FCQ_CMD_PROT 8'hC0

`define FCQ_CNT_MAX_BYTE 16'h001F
`define FCQ_CNT_MAX_WORD 16'h000F
`define FCQ_QUERY_ID_OFF 16'h0010
`define FCQ_READY_BIT 7

`define FCQ_REG_CMD 8'h00
`define FCQ_REG_ADDR 8'h04
`define FCQ_REG_WDATA 8'h08
`define FCQ_REG_STATUS 8'h0C
`define FCQ_REG_RDATA 8'h10
`define FCQ_REG_CFG 8'h14
`define FCQ_REG_BUF 8'h18

`define FCQ_CFG_BYTE 0
`define FCQ_CFG_VPEN 1
`define FCQ_CFG_PDOWN 2
`define FCQ_STS_BUSY 0
`define FCQ_STS_ERR 1
`define FCQ_STS_RP 2
`define FCQ_STS_MODE 4
`define FCQ_STS_FILL 8

`define FCQ_WE_CYC 3
`define FCQ_RD_CYC 4
`define FCQ_RP_CYC 8
`define FCQ_REC_CYC 8

`endif

// ===== logic/fcq_pkg.sv
// Types shared by the flash command host.
// Assumes fcq_defs.svh supplies every numeric constant.
package fcq_pkg;

  typedef enum logic [3:0] {
    FCQ_OP_ARRAY = 4'h0, FCQ_OP_IDENT = 4'h1, FCQ_OP_QUERY = 4'h2,
    FCQ_OP_STATUS = 4'h3, FCQ_OP_CLRST = 4'h4, FCQ_OP_PROG = 4'h5,
    FCQ_OP_ERASE = 4'h6, FCQ_OP_SUSPEND = 4'h7, FCQ_OP_RESUME = 4'h8,
    FCQ_OP_LOCKSET = 4'h9, FCQ_OP_LOCKCLR = 4'hA, FCQ_OP_BUFPROG = 4'hB,
    FCQ_OP_CONFIG = 4'hC, FCQ_OP_PROT = 4'hD
  } fcq_op_type;

  typedef enum logic [3:0] {
    FCQ_K_END = 4'h0, FCQ_K_WCODE = 4'h1, FCQ_K_WPAY = 4'h2,
    FCQ_K_WCNT = 4'h3, FCQ_K_WBUF = 4'h4, FCQ_K_RLO = 4'h5,
    FCQ_K_RHI = 4'h6, FCQ_K_RAVAIL = 4'h7, FCQ_K_RPOLL = 4'h8
  } fcq_kind_type;

  typedef struct packed {
    fcq_kind_type kind;
    logic [7:0] code;
  } fcq_step_type;

  typedef enum logic [2:0] {
    FCQ_ST_RESET = 3'b000, FCQ_ST_IDLE = 3'b001, FCQ_ST_LOAD = 3'b010,
    FCQ_ST_STROBE = 3'b011, FCQ_ST_HOLD = 3'b100, FCQ_ST_GAP = 3'b101
  } fcq_state_type;

  typedef enum logic [1:0] {
    FCQ_MODE_ARRAY = 2'b00, FCQ_MODE_IDENT = 2'b01,
    FCQ_MODE_QUERY = 2'b10, FCQ_MODE_STATUS = 2'b11
  } fcq_mode_type;

endpackage : fcq_pkg

// ===== verif/fcq_flash_model.sv
// Behavioural parallel flash, word or byte mode, driven through its pins; the bench also reads solo and MAKER.
// Assumes one strobe pulse per bus cycle, sampled on the host clock.
module fcq_flash_model #(
  parameter logic [15:0] MAKER = 16'h00A7 // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic [23:0] addr_i,
  input wire logic ce_n_i, oe_n_i, we_n_i, rp_n_i, vpen_i,
  input wire logic byte_n_i, dq_oe_n_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o, last_prog_o,
  output int n_seen_o,
  output logic [1:0] mode_o
);
  logic we_q = 1'b1;
  logic [7:0] pend = 8'h00;
  logic [15:0] junk = 16'h0000;
  int busy = 0;
  int left = 0;
  logic locked = 1'b0;
  logic [7:0] solo = 8'h00;
  logic [23:0] qa;
  // Byte addressing: the lowest line picks a byte, query lives per word
  assign qa = byte_n_i ? addr_i : {1'b0, addr_i[23:1]};
  task automatic cmd(input logic [15:0] d);
    logic [7:0] c;
    c = d[7:0];
    if (pend == 8'hE8) begin
      n_seen_o <= int'(c);
      left <= int'(c) + 1;
      pend <= 8'hEA;
    end else if (pend == 8'hEA && left > 0) left <= left - 1;
    else if (pend != 8'h00) begin
      // A locked block keeps its contents; configuration is not blocked
      if (pend inside {8'hB8, 8'hC0} || pend inside {8'h40, 8'h10} && !locked)
        last_prog_o <= d;
      if (pend == 8'h60) locked <= c == 8'h01;
      // Only a confirm, a lock-set code or program payload starts the engine
      if (vpen_i && (c inside {8'hD0, 8'h01} || pend inside {8'h40, 8'h10}))
        busy <= 20;
      pend <= 8'h00;
      mode_o <= 2'd3;
    end else case (c)
      8'hFF: if (busy == 0) mode_o <= 2'd0;
      8'h90: mode_o <= 2'd1;
      8'h98: mode_o <= 2'd2;
      8'h70: mode_o <= 2'd3;
      8'hE8, 8'h40, 8'h10, 8'h20, 8'h60, 8'hB8, 8'hC0: begin
        pend <= c;
        mode_o <= 2'd3;
      end
      8'hB0, 8'hD0, 8'h50: solo <= c;
      default: ;
    endcase
  endtask
  always @(posedge clk_i) begin
    we_q <= we_n_i;
    junk <= ~junk + 16'h1357;
    if (busy > 0) busy <= busy - 1;
    if (!rp_n_i) begin
      mode_o <= 2'd0;
      pend <= 8'h00;
    end else if (we_n_i && !we_q && !ce_n_i && !dq_oe_n_i) cmd(dq_i);
  end
  always_comb begin
    case (mode_o)
      2'd0: dq_o = addr_i[15:0] ^ 16'hA5C3;
      2'd1: dq_o = MAKER;
      2'd2: dq_o = {8'h00, (qa == 24'h10) ? 8'h51 : (qa == 24'h11) ?
        8'h52 : (qa == 24'h12) ? 8'h59 : 8'h00};
      default: dq_o = busy > 0 ? {junk[15:8], 1'b0, junk[6:0]} : 16'h0080;
    endcase
    if (oe_n_i || ce_n_i) dq_o = junk;
  end
endmodule : fcq_flash_model

// ===== verif/fcq_host_tb.sv
// Self-checking bench: host drives the behavioural flash.
// Assumes the design header and package are compiled first.
`include "fcq_defs.svh"
module fcq_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, q, sts, d, dat_o;
  logic ack, ce_n, oe_n, we_n, rp_n, bn, vpen, oe;
  logic [23:0] fa;
  logic [15:0] fq, dq, lp;
  logic [1:0] fm;
  int n_mismatch = 0, checks_done = 0, cycles = 0, ns;
  int seed = 32'he5e7978c;
  byte qt[$] = '{8'h51, 8'h52, 8'h59, 8'h00};
  fcq_pkg::fcq_op_type ops[4] = '{fcq_pkg::FCQ_OP_ERASE,
    fcq_pkg::FCQ_OP_LOCKSET, fcq_pkg::FCQ_OP_LOCKCLR, fcq_pkg::FCQ_OP_PROT};
  initial forever #2.5 clk = ~clk;
  fcq_host i_dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .flash_addr_o(fa),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
    .flash_rp_n_o(rp_n), .flash_byte_n_o(bn), .flash_vpen_o(vpen),
    .flash_dq_i(fq), .flash_dq_o(dq), .flash_dq_oe_n_o(oe));
  fcq_flash_model i_flash (.clk_i(clk), .addr_i(fa), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .rp_n_i(rp_n), .vpen_i(vpen), .dq_i(dq),
    .dq_o(fq), .last_prog_o(lp), .n_seen_o(ns), .mode_o(fm), .byte_n_i(bn),
    .dq_oe_n_i(oe));
  task automatic end_of_test;
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] v);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic op(input fcq_pkg::fcq_op_type o, input logic [31:0] a);
    wb(`FCQ_REG_ADDR, 1'b1, a);
    wb(`FCQ_REG_CMD, 1'b1, {28'h0, o});
    do wb(`FCQ_REG_STATUS, 1'b0, 32'h0); while (q[`FCQ_STS_BUSY] !== 1'b0);
    sts = q;
    wb(`FCQ_REG_RDATA, 1'b0, 32'h0);
  endtask : op
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    do wb(`FCQ_REG_STATUS, 1'b0, 32'h0);
    while (q[`FCQ_STS_RP] !== 1'b1 || q[`FCQ_STS_BUSY] !== 1'b0);
    chk({30'h0, q[5:4]}, 32'h0);
    op(fcq_pkg::FCQ_OP_IDENT, 32'h0);
    chk(q, {16'h0, i_flash.MAKER});
    for (int i = 0; i < 3; i++) begin
      op(fcq_pkg::FCQ_OP_QUERY, 32'h10 + i);
      chk({30'h0, sts[5:4]}, 32'h2);
      chk(q, {16'h0, qt[i+1], qt[i]});
    end
    wb(`FCQ_REG_CFG, 1'b1, 32'h1);
    op(fcq_pkg::FCQ_OP_QUERY, 32'h10);
    chk(q, {16'h0, qt[1], qt[0]});
    chk({30'h0, sts[5:4]}, {30'h0, fm});
    op(fcq_pkg::FCQ_OP_STATUS, 32'h0);
    chk(q, 32'h80);
    op(fcq_pkg::FCQ_OP_ARRAY, 32'h0);
    chk({30'h0, sts[5:4]}, 32'h0);
    wb(`FCQ_REG_CFG, 1'b1, 32'h2);
    d = $random(seed);
    wb(`FCQ_REG_WDATA, 1'b1, {16'h0, d[31:16]});
    op(fcq_pkg::FCQ_OP_CONFIG, 32'h0);
    chk({16'h0, lp}, {16'h0, d[31:16]});
    wb(`FCQ_REG_WDATA, 1'b1, {16'h0, d[15:0]});
    op(fcq_pkg::FCQ_OP_PROG, {8'h0, d[31:8]});
    chk({16'h0, lp}, {16'h0, d[15:0]});
    foreach (ops[k]) begin
      op(ops[k], 32'h20000);
      chk({24'h0, q[7:0]}, 32'h80);
    end
    op(fcq_pkg::FCQ_OP_LOCKSET, 32'h20000);
    wb(`FCQ_REG_WDATA, 1'b1, {16'h0, ~d[15:0]});
    op(fcq_pkg::FCQ_OP_PROG, 32'h20000);
    chk({16'h0, lp}, {16'h0, d[15:0]});
    op(fcq_pkg::FCQ_OP_LOCKCLR, 32'h0);
    op(fcq_pkg::FCQ_OP_SUSPEND, 32'h0);
    chk({24'h0, i_flash.solo}, {24'h0, `FCQ_CMD_SUSPEND});
    op(fcq_pkg::FCQ_OP_RESUME, 32'h0);
    chk({24'h0, i_flash.solo}, {24'h0, `FCQ_CMD_CONFIRM});
    repeat (3) wb(`FCQ_REG_BUF, 1'b1, $random(seed));
    op(fcq_pkg::FCQ_OP_BUFPROG, 32'h40);
    chk(ns, 32'h2);
    op(fcq_pkg::FCQ_OP_BUFPROG, 32'h40);
    chk({31'h0, sts[`FCQ_STS_ERR]}, 32'h1);
    wb(8'h1C, 1'b0, 32'h0);
    chk(q, 32'h0);
    end_of_test;
  end
endmodule : fcq_host_tb
